// *** design/out_channel.sv ***
`timescale 1ns/100ps
module out_channel import out_chan_pkg::*; #(
  parameter int SCAN_CYCLES = SCAN_CYCLES_DEF,
  parameter int CHAN_NUM = 1,
  parameter logic [15:0] REF_BASE = 16'h0000,
  parameter logic [15:0] RANGE_HI = RANGE_HI_RESET,
  parameter logic [15:0] RANGE_LO = RANGE_LO_RESET
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Field fault sense pins.
  input wire logic open_wire_pin,
  input wire logic short_pin,
  // Output stage.
  output logic [15:0] out_value,
  output logic [15:0] dac_code,
  output logic scan_tick,
  // Responses toward the controller.
  output logic [7:0] diag_bits,
  output logic [7:0] fault_vec,
  output logic fault_evt,
  output logic [7:0] irq_vec,
  output logic irq_evt,
  output logic [15:0] irq_ref_addr
);
  if (SCAN_CYCLES < 2 || CHAN_NUM < 1)
  begin : g_bad_param
    $error("out_channel: SCAN_CYCLES must be at least 2 and CHAN_NUM at least 1.");
  end

  logic [15:0] cfg [NUM_CFG];
  logic [31:0] scan_cnt;
  logic [1:0] open_sync;
  logic [1:0] short_sync;
  logic [7:0] cond;
  logic [7:0] irq_seen;
  logic [15:0] fcount;

  // APB decode.
  wire access = psel & penable;
  wire setup = psel & ~penable;
  wire aligned = paddr[1:0] == 2'b00;
  wire cfg_hit = aligned & (paddr < ADDR_STATUS);
  wire ro_hit = aligned & (paddr >= ADDR_STATUS) & (paddr <= ADDR_COND);
  wire bad = ~(cfg_hit | ro_hit) | (pwrite & ro_hit);
  wire cfg_we = access & pwrite & cfg_hit;
  wire [3:0] idx = paddr[5:2];
  wire [15:0] rd_word = cfg_hit ? cfg[idx] :
                        (paddr == ADDR_STATUS) ? {8'h00, diag_bits} :
                        (paddr == ADDR_VALUE) ? out_value :
                        (paddr == ADDR_DAC) ? dac_code :
                        (paddr == ADDR_FCOUNT) ? fcount :
                        (paddr == ADDR_COND) ? {8'h00, cond} : 16'h0000;
  assign pready = 1'b1;
  assign pslverr = access & bad;

  // Configuration fields.
  wire [15:0] ctrl = cfg[ADDR_CTRL[5:2]];
  wire out_en = ctrl[CTRL_OUT_EN];
  wire hold = ctrl[CTRL_HOLD];
  wire clamp_en = ctrl[CTRL_CLAMP_EN];
  wire cur_mode = ctrl[CTRL_CUR_MODE];
  wire diag_en = ctrl[CTRL_DIAG_EN];
  wire fault_en = ctrl[CTRL_FAULT_EN];
  wire irq_en = ctrl[CTRL_IRQ_EN];
  wire signed [15:0] cmd = cfg[ADDR_CMD[5:2]];
  wire signed [15:0] offset = cfg[ADDR_OFFSET[5:2]];
  wire signed [15:0] hi_alarm = cfg[ADDR_HI_ALARM[5:2]];
  wire signed [15:0] lo_alarm = cfg[ADDR_LO_ALARM[5:2]];
  wire [15:0] rate_norm = cfg[ADDR_RATE_NORM[5:2]];
  wire [15:0] rate_def = cfg[ADDR_RATE_DEF[5:2]];
  wire signed [15:0] uclamp = cfg[ADDR_UCLAMP[5:2]];
  wire signed [15:0] lclamp = cfg[ADDR_LCLAMP[5:2]];
  wire signed [15:0] def_val = cfg[ADDR_DEFAULT[5:2]];
  wire [7:0] diag_mask = cfg[ADDR_DIAG_MASK[5:2]][7:0];
  wire [7:0] fault_mask = cfg[ADDR_FAULT_MASK[5:2]][7:0];
  wire [7:0] irq_mask = cfg[ADDR_IRQ_MASK[5:2]][7:0];
  wire signed [15:0] gain = cfg[ADDR_GAIN[5:2]];
  wire signed [15:0] lo_out = cfg[ADDR_LO_OUT[5:2]];
  wire signed [15:0] lo_eng = cfg[ADDR_LO_ENG[5:2]];

  // Detected field faults, qualified by the output mode.
  wire open_det = open_sync[1] & cur_mode;
  wire short_det = short_sync[1] & ~cur_mode;
  wire fault_any = ctrl[CTRL_FAULT_MODE] | open_det | short_det;
  wire active = out_en & ~fault_any;

  // Target selection, offset and clamping.
  wire signed [15:0] cur = out_value;
  wire signed [15:0] src = active ? 16'(cmd + offset) :
                           hold ? cur : def_val;
  wire over_u = clamp_en & (src > uclamp);
  wire under_l = clamp_en & (src < lclamp);
  wire signed [15:0] target = over_u ? uclamp : under_l ? lclamp : src;

  // Ramp toward the target one step per scan.
  wire [15:0] rate = active ? rate_norm : rate_def;
  wire signed [17:0] cur_x = 18'(cur);
  wire signed [17:0] tgt_x = 18'(target);
  wire signed [17:0] up_x = cur_x + $signed({2'b00, rate});
  wire signed [17:0] dn_x = cur_x - $signed({2'b00, rate});
  wire signed [15:0] next_value = (rate == 16'h0000) ? target :
                                  (tgt_x > cur_x) ? ((up_x >= tgt_x) ? target : up_x[15:0]) :
                                  ((dn_x <= tgt_x) ? target : dn_x[15:0]);

  // Alarm conditions on the final value and on the commanded value.
  wire [7:0] next_cond;
  assign next_cond[C_LOW] = next_value <= lo_alarm;
  assign next_cond[C_HIGH] = next_value >= hi_alarm;
  assign next_cond[C_UNDER] = src < $signed(RANGE_LO);
  assign next_cond[C_OVER] = src > $signed(RANGE_HI);
  assign next_cond[C_OPEN] = open_det;
  assign next_cond[C_LCLAMP] = under_l;
  assign next_cond[C_UCLAMP] = over_u;

  assign next_cond[C_SHORT] = short_det;

  // Linear scaling from engineering units to converter units.
  wire signed [16:0] diff = 17'(cur) - 17'(lo_eng);
  wire signed [32:0] prod = diff * gain;
  wire signed [15:0] next_dac = 16'(lo_out + $signed(prod[GAIN_FRAC_BITS +: 16]));

  wire next_scan = scan_cnt == 32'(SCAN_CYCLES - 1);
  wire [7:0] fault_raw;
  wire [7:0] irq_raw;
  wire [7:0] next_diag = (cond & diag_mask & {8{diag_en}}) | irq_seen | irq_raw;

  resp_gate #(.W(NUM_COND)) u_fault_gate (
    .clk(pclk),
    .rstn(presetn),
    .cond(cond),
    .cat_en(fault_en),
    .mask(fault_mask),
    .evt(fault_raw)
  );
  resp_gate #(.W(NUM_COND)) u_irq_gate (
    .clk(pclk),
    .rstn(presetn),
    .cond(cond),
    .cat_en(irq_en),
    .mask(irq_mask),
    .evt(irq_raw)
  );

  assign fault_vec = fault_raw;
  assign irq_vec = irq_raw;
  assign fault_evt = |fault_raw;
  assign irq_evt = |irq_raw;
  assign irq_ref_addr = 16'(REF_BASE + REF_WORDS_PER_CHAN * (CHAN_NUM - 1));

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < NUM_CFG; i++)
        cfg[i] <= CFG_RESET[i*16 +: 16];
    end
    else if (cfg_we)
      cfg[idx] <= pwdata[15:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h00000000;
    else if (setup)
      prdata <= {16'h0000, rd_word};
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      open_sync <= 2'b00;
      short_sync <= 2'b00;
      scan_cnt <= 32'h00000000;
      scan_tick <= 1'b0;
    end
    else
    begin
      open_sync <= {open_sync[0], open_wire_pin};
      short_sync <= {short_sync[0], short_pin};
      scan_cnt <= next_scan ? 32'h00000000 : scan_cnt + 32'h00000001;
      scan_tick <= next_scan;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      out_value <= 16'h0000;
      cond <= 8'h00;
    end
    else if (scan_tick)
    begin
      out_value <= next_value;
      cond <= next_cond;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_seen <= 8'h00;
      diag_bits <= 8'h00;
      dac_code <= 16'h0000;
      fcount <= 16'h0000;
    end
    else
    begin
      irq_seen <= irq_raw | (scan_tick ? 8'h00 : irq_seen);
      diag_bits <= next_diag;
      dac_code <= next_dac;
      fcount <= fcount + 16'($countones(fault_raw));
    end
  end

  property p_low_alarm;
    @(posedge pclk) disable iff (!presetn)
    scan_tick |=> cond[C_LOW] == ($signed(out_value) <= $signed($past(lo_alarm)));
  endproperty
  a_low_alarm: assert property (p_low_alarm) else $error("Low alarm mismatch.");

  property p_high_alarm;
    @(posedge pclk) disable iff (!presetn)
    scan_tick |=> cond[C_HIGH] == ($signed(out_value) >= $signed($past(hi_alarm)));
  endproperty
  a_high_alarm: assert property (p_high_alarm) else $error("High alarm mismatch.");

  property p_zero_rate;
    @(posedge pclk) disable iff (!presetn)
    scan_tick && rate == 16'h0000 |=> out_value == $past(target);
  endproperty
  a_zero_rate: assert property (p_zero_rate) else $error("Zero rate did not jump.");

  property p_ramp_step;
    @(posedge pclk) disable iff (!presetn)
    scan_tick && rate != 16'h0000 && tgt_x > up_x |=> out_value == $past(up_x[15:0]);
  endproperty
  a_ramp_step: assert property (p_ramp_step) else $error("Ramp step wrong.");

  property p_uclamp;
    @(posedge pclk) disable iff (!presetn)
    scan_tick && clamp_en && src > uclamp |=> cond[C_UCLAMP] && !cond[C_LCLAMP];
  endproperty
  a_uclamp: assert property (p_uclamp) else $error("Upper clamp not flagged.");

  property p_lclamp;
    @(posedge pclk) disable iff (!presetn)
    scan_tick && clamp_en && src < lclamp && rate == 16'h0000 |=>
      cond[C_LCLAMP] && out_value == $past(lclamp);
  endproperty
  a_lclamp: assert property (p_lclamp) else $error("Lower clamp wrong.");

  property p_default;
    @(posedge pclk) disable iff (!presetn)
    scan_tick && !active && !hold && !clamp_en && rate_def == 16'h0000 |=>
      out_value == $past(def_val);
  endproperty
  a_default: assert property (p_default) else $error("Default value not applied.");

  property p_offset;
    @(posedge pclk) disable iff (!presetn)
    scan_tick && active && !clamp_en && rate_norm == 16'h0000 |=>
      out_value == 16'($past(cmd) + $past(offset));
  endproperty
  a_offset: assert property (p_offset) else $error("Offset not applied.");

  property p_fault_evt;
    @(posedge pclk) disable iff (!presetn)
    fault_en && ((cond & ~$past(cond) & fault_mask) != 8'h00) |=> fault_evt;
  endproperty
  a_fault_evt: assert property (p_fault_evt) else $error("Fault entry missing.");

  property p_irq_mask;
    @(posedge pclk) disable iff (!presetn)
    irq_evt |-> (irq_vec & ~$past(irq_mask)) == 8'h00 && $past(irq_en);
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("Masked interrupt fired.");

  property p_irq_diag;
    @(posedge pclk) disable iff (!presetn)
    irq_evt && !scan_tick |=> (diag_bits & $past(irq_vec)) == $past(irq_vec);
  endproperty
  a_irq_diag: assert property (p_irq_diag) else $error("Interrupt diag bit not set.");

  property p_irq_addr;
    @(posedge pclk) disable iff (!presetn)
    irq_evt |-> irq_ref_addr == 16'(REF_BASE + 2 * (CHAN_NUM - 1));
  endproperty
  a_irq_addr: assert property (p_irq_addr) else $error("Interrupt address wrong.");

  property p_diag_off;
    @(posedge pclk) disable iff (!presetn)
    !diag_en && irq_seen == 8'h00 && irq_raw == 8'h00 |=> diag_bits == 8'h00;
  endproperty
  a_diag_off: assert property (p_diag_off) else $error("Diag bit set while off.");

  property p_open_mode;
    @(posedge pclk) disable iff (!presetn)
    scan_tick && !cur_mode |=> !cond[C_OPEN];
  endproperty
  a_open_mode: assert property (p_open_mode) else $error("Open wire in voltage mode.");

  property p_short_mode;
    @(posedge pclk) disable iff (!presetn)
    scan_tick && cur_mode |=> !cond[C_SHORT];
  endproperty
  a_short_mode: assert property (p_short_mode) else $error("Short in current mode.");

  property p_diag_report;
    @(posedge pclk) disable iff (!presetn)
    diag_en && irq_seen == 8'h00 && irq_raw == 8'h00 |=> diag_bits == ($past(cond) & $past(diag_mask));
  endproperty
  a_diag_report: assert property (p_diag_report) else $error("Diag bits wrong.");

  property p_irq_clear;
    @(posedge pclk) disable iff (!presetn)
    scan_tick && irq_raw == 8'h00 |=> irq_seen == 8'h00;
  endproperty
  a_irq_clear: assert property (p_irq_clear) else $error("Interrupt bit not cleared.");

  property p_fault_mask;
    @(posedge pclk) disable iff (!presetn)
    fault_evt |-> (fault_vec & ~$past(fault_mask)) == 8'h00 && $past(fault_en);
  endproperty
  a_fault_mask: assert property (p_fault_mask) else $error("Masked fault logged.");

  c_ramp: cover property (@(posedge pclk) disable iff (!presetn) scan_tick && rate != 16'h0000);
  c_fault: cover property (@(posedge pclk) disable iff (!presetn) fault_evt);
  c_irq: cover property (@(posedge pclk) disable iff (!presetn) irq_evt && !diag_en);
  c_clamp: cover property (@(posedge pclk) disable iff (!presetn) cond[C_UCLAMP]);
  c_hold: cover property (@(posedge pclk) disable iff (!presetn) scan_tick && hold && !active);
endmodule // out_channel

// *** design/out_chan_pkg.sv ***
// Behaviour
// - Low and high alarms compare inclusively.
// - Normal rate when enabled, default otherwise; code also uses default rate in fault mode or on a detected field fault.
// - Clamp above upper limit, flag upper clamp.
// - Clamp below lower limit, flag lower clamp.
// - Default value when not holding last state.
// - User offset added before alarm checks.
// - Eight alarms, each with three response kinds.
// - High/low alarms use final output value.
// - Enabled diagnostics show alarms as status bits.
// - One fault entry per enabled alarm occurrence.
// - One interrupt event per enabled alarm occurrence; code gives one irq_evt for all alarms raised in the same cycle.
// - Cleared enable suppresses that response kind.
// - Open wire in current, short in voltage.
// - All responses off at reset, independent enables.
// - Interrupt sets diag bit until next scan.
// - Interrupt names channel reference word address.
// - Diagnostic one means present, zero absent.
// - Linear scaling, inverse allowed.
package out_chan_pkg;
  localparam int NUM_CFG = 16;
  localparam int NUM_COND = 8;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CMD = 8'h04;
  localparam logic [7:0] ADDR_OFFSET = 8'h08;
  localparam logic [7:0] ADDR_HI_ALARM = 8'h0C;
  localparam logic [7:0] ADDR_LO_ALARM = 8'h10;
  localparam logic [7:0] ADDR_RATE_NORM = 8'h14;
  localparam logic [7:0] ADDR_RATE_DEF = 8'h18;
  localparam logic [7:0] ADDR_UCLAMP = 8'h1C;
  localparam logic [7:0] ADDR_LCLAMP = 8'h20;
  localparam logic [7:0] ADDR_DEFAULT = 8'h24;
  localparam logic [7:0] ADDR_DIAG_MASK = 8'h28;
  localparam logic [7:0] ADDR_FAULT_MASK = 8'h2C;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h30;
  localparam logic [7:0] ADDR_GAIN = 8'h34;
  localparam logic [7:0] ADDR_LO_OUT = 8'h38;
  localparam logic [7:0] ADDR_LO_ENG = 8'h3C;
  localparam logic [7:0] ADDR_STATUS = 8'h40;
  localparam logic [7:0] ADDR_VALUE = 8'h44;
  localparam logic [7:0] ADDR_DAC = 8'h48;
  localparam logic [7:0] ADDR_FCOUNT = 8'h4C;
  localparam logic [7:0] ADDR_COND = 8'h50;
  localparam int CTRL_OUT_EN = 0;
  localparam int CTRL_HOLD = 1;
  localparam int CTRL_CLAMP_EN = 2;
  localparam int CTRL_CUR_MODE = 3;
  localparam int CTRL_DIAG_EN = 4;
  localparam int CTRL_FAULT_EN = 5;
  localparam int CTRL_IRQ_EN = 6;
  localparam int CTRL_FAULT_MODE = 7;
  localparam int C_LOW = 0;
  localparam int C_HIGH = 1;
  localparam int C_UNDER = 2;
  localparam int C_OVER = 3;
  localparam int C_OPEN = 4;
  localparam int C_LCLAMP = 5;
  localparam int C_UCLAMP = 6;
  localparam int C_SHORT = 7;
  localparam logic [NUM_CFG*16-1:0] CFG_RESET = {
    16'h0000, 16'h0000, 16'h0100, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h8000,
    16'h7FFF, 16'h0000, 16'h0000, 16'h8000, 16'h7FFF, 16'h0000, 16'h0000, 16'h0000};
  localparam logic [15:0] RANGE_HI_RESET = 16'h7FFF;
  localparam logic [15:0] RANGE_LO_RESET = 16'h8000;
  localparam int SCAN_TIME_US = 1000;
  localparam int CLK_MHZ = 10;
  localparam int SCAN_CYCLES_DEF = SCAN_TIME_US * CLK_MHZ;
  localparam int REF_WORDS_PER_CHAN = 2;
  localparam int GAIN_FRAC_BITS = 8;
endpackage

// *** design/resp_gate.sv ***
`timescale 1ns/100ps
module resp_gate #(
  parameter int W = 8
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // Condition vector and enables.
  input wire logic [W-1:0] cond,
  input wire logic cat_en,
  input wire logic [W-1:0] mask,
  // One-cycle event per newly raised enabled condition.
  output logic [W-1:0] evt
);
  logic [W-1:0] prev;
  wire [W-1:0] next_evt = cond & ~prev & mask & {W{cat_en}};

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      prev <= '0;
      evt <= '0;
    end
    else
    begin
      prev <= cond;
      evt <= next_evt;
    end
  end
endmodule // resp_gate

// *** tb/ctrl_model.sv ***
`timescale 1ns/100ps
module ctrl_model (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Responses from the channel.
  input wire logic [7:0] fault_vec,
  input wire logic irq_evt,
  input wire logic [15:0] irq_ref_addr,
  // Logged totals.
  output logic [15:0] fault_entries,
  output logic [15:0] irq_events,
  output logic [15:0] irq_last_addr
);
  // Logs fault entries and the reference word of each interrupt.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fault_entries <= 16'h0000;
      irq_events <= 16'h0000;
      irq_last_addr <= 16'h0000;
    end
    else
    begin
      fault_entries <= fault_entries + 16'($countones(fault_vec));
      if (irq_evt)
      begin
        irq_events <= irq_events + 16'h0001;
        irq_last_addr <= irq_ref_addr;
      end
    end
  end
endmodule // ctrl_model

// *** tb/tb_top.sv ***
`timescale 1ns/100ps
module tb_top import out_chan_pkg::*;;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic open_wire_pin = 1'b0;
  logic short_pin = 1'b0;
  logic [15:0] out_value;
  logic [15:0] dac_code;
  logic scan_tick;
  logic [7:0] diag_bits;
  logic [7:0] fault_vec;
  logic fault_evt;
  logic [7:0] irq_vec;
  logic irq_evt;
  logic [15:0] irq_ref_addr;
  logic [15:0] fault_entries;
  logic [15:0] irq_events;
  logic [15:0] irq_last_addr;
  logic [31:0] rdat;
  logic rerr;
  int miscompares = 0;
  int compares = 0;
  always #50 pclk = ~pclk;
  out_channel #(.SCAN_CYCLES(8), .CHAN_NUM(3), .REF_BASE(16'h0100), .RANGE_HI(16'h0400),
    .RANGE_LO(16'hFC00)) dut_u (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .open_wire_pin(open_wire_pin), .short_pin(short_pin), .out_value(out_value),
    .dac_code(dac_code), .scan_tick(scan_tick), .diag_bits(diag_bits),
    .fault_vec(fault_vec), .fault_evt(fault_evt), .irq_vec(irq_vec), .irq_evt(irq_evt),
    .irq_ref_addr(irq_ref_addr));
  ctrl_model ctrl_u (
    .pclk(pclk), .presetn(presetn), .fault_vec(fault_vec), .irq_evt(irq_evt),
    .irq_ref_addr(irq_ref_addr), .fault_entries(fault_entries),
    .irq_events(irq_events), .irq_last_addr(irq_last_addr));
  task automatic end_of_test();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic hang();
    miscompares++;
    end_of_test();
  endtask
  // One APB transfer; the request holds until pready is seen high.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
      hang();
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rdat, exp);
  endtask
  // Returns once the k-th scan that follows the call has updated out_value.
  task automatic wait_scan(input int k);
    int n;
    repeat (k)
    begin
      n = 0;
      do
      begin
        @(posedge pclk);
        #1;
        n++;
      end
      while (scan_tick !== 1'b1 && n < 40);
      if (scan_tick !== 1'b1)
        hang();
      @(posedge pclk);
      #1;
    end
  endtask
  task automatic t_reset();
    int n;
    rd_chk(ADDR_CTRL, 32'h0);
    rd_chk(ADDR_HI_ALARM, 32'h7FFF);
    rd_chk(ADDR_UCLAMP, 32'h7FFF);
    rd_chk(ADDR_GAIN, 32'h0100);
    rd_chk(ADDR_FAULT_MASK, 32'h0);
    rd_chk(ADDR_IRQ_MASK, 32'h0);
    apb(1'b0, 8'h7C, 32'h0);
    check({rdat[30:0], rerr}, 32'h1);
    apb(1'b1, ADDR_STATUS, 32'hFF);
    check({31'h0, rerr}, 32'h1);
    check({16'h0, out_value}, 32'h0);
    wait_scan(1);
    n = 0;
    do
    begin
      @(posedge pclk);
      #1;
      n++;
    end
    while (scan_tick !== 1'b1 && n < 40);
    check(32'(n), 32'h7);
    $display("t_reset done");
  endtask
  task automatic t_direct();
    wr(ADDR_OFFSET, 32'h0010);
    wr(ADDR_DIAG_MASK, 32'hFF);
    wr(ADDR_CMD, 32'h0100);
    wr(ADDR_CTRL, 32'h11);
    wait_scan(2);
    check({16'h0, out_value}, 32'h0110);
    check({16'h0, dac_code}, 32'h0110);
    rd_chk(ADDR_STATUS, 32'h0);
    wr(ADDR_HI_ALARM, 32'h0110);
    wr(ADDR_LO_ALARM, 32'h0110);
    wr(ADDR_GAIN, 32'hFF00);
    wait_scan(2);
    check({16'h0, dac_code}, 32'hFEF0);
    rd_chk(ADDR_STATUS, 32'h03);
    wr(ADDR_HI_ALARM, 32'h7FFF);
    wr(ADDR_LO_ALARM, 32'h8000);
    wr(ADDR_GAIN, 32'h0100);
    $display("t_direct done");
  endtask
  task automatic t_clamp();
    wr(ADDR_HI_ALARM, 32'h0250);
    wr(ADDR_UCLAMP, 32'h0200);
    wr(ADDR_LCLAMP, 32'hFE00);
    wr(ADDR_OFFSET, 32'h0);
    wr(ADDR_CMD, 32'h0300);
    wr(ADDR_CTRL, 32'h15);
    wait_scan(2);
    check({16'h0, out_value}, 32'h0200);
    rd_chk(ADDR_STATUS, 32'h40);
    wr(ADDR_CMD, 32'hFC00);
    wait_scan(2);
    check({16'h0, out_value}, 32'hFE00);
    rd_chk(ADDR_STATUS, 32'h20);
    wr(ADDR_CMD, 32'h0500);
    wait_scan(2);
    rd_chk(ADDR_STATUS, 32'h48);
    wr(ADDR_CMD, 32'hFB00);
    wait_scan(2);
    rd_chk(ADDR_STATUS, 32'h24);
    wr(ADDR_HI_ALARM, 32'h7FFF);
    $display("t_clamp done");
  endtask
  task automatic t_ramp();
    wr(ADDR_CTRL, 32'h11);
    wr(ADDR_CMD, 32'h0);
    wait_scan(2);
    wr(ADDR_RATE_NORM, 32'h0010);
    wr(ADDR_CMD, 32'h0040);
    for (int i = 1; i <= 5; i++)
    begin
      wait_scan(1);
      check({16'h0, out_value}, (i < 4) ? 32'(i * 16) : 32'h40);
    end
    wr(ADDR_RATE_DEF, 32'h0020);
    wr(ADDR_CTRL, 32'h10);
    wait_scan(1);
    check({16'h0, out_value}, 32'h0020);
    wait_scan(1);
    check({16'h0, out_value}, 32'h0000);
    wr(ADDR_RATE_DEF, 32'h0);
    wr(ADDR_DEFAULT, 32'h0123);
    wait_scan(2);
    check({16'h0, out_value}, 32'h0123);
    wr(ADDR_CTRL, 32'h12);
    wr(ADDR_DEFAULT, 32'h0);
    wait_scan(2);
    check({16'h0, out_value}, 32'h0123);
    wr(ADDR_CTRL, 32'h91);
    wait_scan(2);
    check({16'h0, out_value}, 32'h0000);
    wr(ADDR_RATE_NORM, 32'h0);
    $display("t_ramp done");
  endtask
  task automatic t_resp();
    int n;
    wr(ADDR_DIAG_MASK, 32'h0);
    wr(ADDR_FAULT_MASK, 32'h02);
    wr(ADDR_IRQ_MASK, 32'h02);
    wr(ADDR_HI_ALARM, 32'h0100);
    wr(ADDR_CMD, 32'h0);
    wr(ADDR_CTRL, 32'h61);
    wait_scan(2);
    wr(ADDR_CMD, 32'h0200);
    n = 0;
    do
    begin
      @(posedge pclk);
      #1;
      n++;
    end
    while (irq_evt !== 1'b1 && n < 40);
    if (irq_evt !== 1'b1)
      hang();
    check({24'h0, irq_vec}, 32'h02);
    check({23'h0, fault_evt, fault_vec}, 32'h102);
    rd_chk(ADDR_STATUS, 32'h02);
    wait_scan(2);
    rd_chk(ADDR_STATUS, 32'h0);
    wr(ADDR_CMD, 32'h0);
    wait_scan(2);
    wr(ADDR_CMD, 32'h0200);
    wait_scan(2);
    wr(ADDR_LO_ALARM, 32'h0);
    wr(ADDR_CMD, 32'hFF00);
    wait_scan(2);
    check({16'h0, fault_entries}, 32'h2);
    check({16'h0, irq_events}, 32'h2);
    check({16'h0, irq_last_addr}, 32'h0104);
    rd_chk(ADDR_FCOUNT, 32'h2);
    wr(ADDR_LO_ALARM, 32'h8000);
    $display("t_resp done");
  endtask
  task automatic t_wire();
    wr(ADDR_DIAG_MASK, 32'hFF);
    wr(ADDR_CMD, 32'h0);
    wr(ADDR_CTRL, 32'h11);
    @(posedge pclk);
    open_wire_pin <= 1'b1;
    wait_scan(2);
    rd_chk(ADDR_STATUS, 32'h0);
    wr(ADDR_CTRL, 32'h19);
    wait_scan(2);
    apb(1'b0, ADDR_STATUS, 32'h0);
    check(rdat & 32'h90, 32'h10);
    open_wire_pin <= 1'b0;
    short_pin <= 1'b1;
    wait_scan(2);
    apb(1'b0, ADDR_STATUS, 32'h0);
    check(rdat & 32'h90, 32'h00);
    wr(ADDR_CTRL, 32'h11);
    wait_scan(2);
    apb(1'b0, ADDR_STATUS, 32'h0);
    check(rdat & 32'h90, 32'h80);
    short_pin <= 1'b0;
    $display("t_wire done");
  endtask
  initial
  begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_direct();
    t_clamp();
    t_ramp();
    t_resp();
    t_wire();
    end_of_test();
  end
endmodule // tb_top
